// ---- common/burner_mon_pkg.sv ----
// Constants, field layouts and carrier types for the burner sequence monitor.
// Assumes a single 100 MHz system clock and a plain register port.
package burner_mon_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [23:0] TICK_LAST = 24'(TICK_CYC - 1);
    localparam int unsigned AIR_WAIT_S = 30;
    localparam logic [8:0] AIR_WAIT_TICKS = 9'(AIR_WAIT_S * 1000 / TICK_MS);
    localparam int unsigned FLICKER_MS = 500;
    localparam logic [2:0] FLICKER_TICKS = 3'(FLICKER_MS / TICK_MS);
    localparam logic [6:0] TICKS_PER_S = 7'(1000 / TICK_MS);
    localparam logic [3:0] OFF_DELAY_MAX_S = 4'ha;

    localparam int unsigned N_IN = 4;
    localparam int unsigned N_MON = 11;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DELAY = 4'h1;
    localparam logic [3:0] ADDR_FUNC = 4'h2;
    localparam logic [3:0] ADDR_SEL_LO = 4'h3;
    localparam logic [3:0] ADDR_SEL_HI = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_MON = 4'h6;

    localparam int unsigned CTRL_LINKED_BIT = 0;
    localparam int unsigned CTRL_FLICKER_BIT = 1;
    localparam int unsigned CTRL_DUAL_BIT = 2;
    localparam int unsigned CTRL_RESET_BIT = 3;

    typedef enum logic [1:0] {
        FUNC_UNUSED = 2'h0,
        FUNC_CONTROL = 2'h1,
        FUNC_INTERLOCK = 2'h2
    } in_func_t;

    typedef enum logic [3:0] {
        SEL_FIRST_OUT_1 = 4'h0,
        SEL_FIRST_OUT_2 = 4'h1,
        SEL_FIRST_OUT_3 = 4'h2,
        SEL_FIRST_OUT_4 = 4'h3,
        SEL_IGNITION = 4'h4,
        SEL_PILOT = 4'h5,
        SEL_MAIN = 4'h6,
        SEL_FLAME_PRI = 4'h7,
        SEL_FLAME_SEC = 4'h8,
        SEL_LOCKOUT = 4'h9,
        SEL_IGN_FAIL = 4'ha,
        SEL_OFF = 4'hf
    } mon_sel_t;

    typedef enum logic [3:0] {
        stage_pilot_only = 4'b0001,
        stage_main_trial = 4'b0010,
        stage_air_wait = 4'b0100,
        stage_locked = 4'b1000
    } stage_t;

    typedef struct packed {
        logic ignition_load;
        logic pilot_valve_load;
        logic main_valve_load;
        logic flame_pri;
        logic flame_sec;
        logic ignition_failure_err;
    } plant_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ---- src/burner_seq_monitor.sv ----
// Burner main-start sequencing, interlock OFF delays and eleven monitor outputs.
// Assumes field inputs are synchronous and debounced; registers via a plain port.
//
// Implementation choices: the register offsets and strobed register access.
module burner_seq_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire burner_mon_pkg::reg_req_t req_i,
    output logic [31:0] rdata_o,
    input wire logic main_start_i,
    input wire logic air_switch_i,
    input wire logic main_trial_done_i,
    input wire logic [3:0] field_inputs_i,
    input wire burner_mon_pkg::plant_t plant_i,
    output logic [3:0] stage_o,
    output logic lockout_o,
    output logic [10:0] monitor_out_lines_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [23:0] tick_cnt;
        logic tick;
        logic [2:0] flick_cnt;
        logic flick;
        burner_mon_pkg::stage_t stage;
        logic [8:0] air_cnt;
        logic [3:0][6:0] sub_cnt;
        logic [3:0][3:0] sec_cnt;
        logic [3:0] held;
        logic [3:0] first_out;
        logic ign_fail;
        logic [3:0][3:0] delay_s;
        logic [3:0][1:0] func;
        logic [10:0][3:0] sel;
        logic linked;
        logic flicker_en;
        logic dual;
        logic [10:0] mon;
        logic [31:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic sel_value(input logic [3:0] sel, input logic [3:0] fo,
                                       input burner_mon_pkg::plant_t p, input logic lk,
                                       input logic ig, input logic dual);
        logic v;
        v = 1'b0;
        unique case (sel)
            burner_mon_pkg::SEL_FIRST_OUT_1: v = fo[0];
            burner_mon_pkg::SEL_FIRST_OUT_2: v = fo[1];
            burner_mon_pkg::SEL_FIRST_OUT_3: v = fo[2];
            burner_mon_pkg::SEL_FIRST_OUT_4: v = fo[3];
            burner_mon_pkg::SEL_IGNITION: v = p.ignition_load;
            burner_mon_pkg::SEL_PILOT: v = p.pilot_valve_load;
            burner_mon_pkg::SEL_MAIN: v = p.main_valve_load;
            burner_mon_pkg::SEL_FLAME_PRI: v = p.flame_pri;
            burner_mon_pkg::SEL_FLAME_SEC: v = p.flame_sec & dual;
            burner_mon_pkg::SEL_LOCKOUT: v = lk;
            burner_mon_pkg::SEL_IGN_FAIL: v = ig;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic locked;
    logic err_reset;
    logic [3:0] fo_view;
    logic [3:0] delay_done;
    logic [3:0] ctrl_fo;
    logic [3:0] ilk_trip;

    assign locked = (s_reg.stage == burner_mon_pkg::stage_locked);
    assign err_reset = req_i.wr && (req_i.addr == burner_mon_pkg::ADDR_CTRL)
        && req_i.wdata[burner_mon_pkg::CTRL_RESET_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_in
            // A zero delay expires at once, so an open interlock trips immediately
            assign delay_done[gi] = (s_reg.sec_cnt[gi] >= s_reg.delay_s[gi]);
            assign ilk_trip[gi] = (s_reg.func[gi] == burner_mon_pkg::FUNC_INTERLOCK)
                && !field_inputs_i[gi] && delay_done[gi];
            assign ctrl_fo[gi] = field_inputs_i[gi] || (s_reg.held[gi] && !delay_done[gi]);
            always_comb
            begin
                unique case (s_reg.func[gi])
                    burner_mon_pkg::FUNC_CONTROL: fo_view[gi] = ctrl_fo[gi];
                    burner_mon_pkg::FUNC_INTERLOCK:
                        // Closed contact or normal run shows off; lockout shows first-out only
                        fo_view[gi] = locked && s_reg.first_out[gi]
                            && (s_reg.flicker_en ? s_reg.flick : 1'b1);
                    default: fo_view[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt == burner_mon_pkg::TICK_LAST)
        begin
            s_next.tick_cnt = '0;
            s_next.tick = 1'b1;
        end
        else
        begin
            s_next.tick_cnt = s_reg.tick_cnt + 24'h1;
        end
        if (s_reg.tick)
        begin
            if (s_reg.flick_cnt == burner_mon_pkg::FLICKER_TICKS - 3'h1)
            begin
                s_next.flick_cnt = '0;
                s_next.flick = !s_reg.flick;
            end
            else
            begin
                s_next.flick_cnt = s_reg.flick_cnt + 3'h1;
            end
        end

        // OFF delay counters run while an input is open, whatever its function
        for (int i = 0; i < 4; i++)
        begin
            if (field_inputs_i[i])
            begin
                s_next.sub_cnt[i] = '0;
                s_next.sec_cnt[i] = '0;
                s_next.held[i] = 1'b1;
            end
            else if (!delay_done[i] && s_reg.tick)
            begin
                if (s_reg.sub_cnt[i] == burner_mon_pkg::TICKS_PER_S - 7'h1)
                begin
                    s_next.sub_cnt[i] = '0;
                    s_next.sec_cnt[i] = s_reg.sec_cnt[i] + 4'h1;
                end
                else
                begin
                    s_next.sub_cnt[i] = s_reg.sub_cnt[i] + 7'h1;
                end
            end
            else if (delay_done[i])
            begin
                s_next.held[i] = 1'b0;
            end
        end

        unique case (s_reg.stage)
            burner_mon_pkg::stage_pilot_only:
                if (main_start_i)
                begin
                    if (s_reg.linked && !air_switch_i)
                    begin
                        s_next.stage = burner_mon_pkg::stage_air_wait;
                        s_next.air_cnt = '0;
                    end
                    else
                    begin
                        s_next.stage = burner_mon_pkg::stage_main_trial;
                    end
                end
            burner_mon_pkg::stage_air_wait:
                // Main start is not looked at here, so dropping it changes nothing
                if (air_switch_i)
                begin
                    s_next.stage = burner_mon_pkg::stage_main_trial;
                end
                else if (s_reg.air_cnt == burner_mon_pkg::AIR_WAIT_TICKS)
                begin
                    s_next.stage = burner_mon_pkg::stage_locked;
                end
                else if (s_reg.tick)
                begin
                    s_next.air_cnt = s_reg.air_cnt + 9'h1;
                end
            burner_mon_pkg::stage_main_trial:
                if (main_trial_done_i)
                begin
                    s_next.stage = burner_mon_pkg::stage_pilot_only;
                end
            burner_mon_pkg::stage_locked:
                if (err_reset)
                begin
                    s_next.stage = burner_mon_pkg::stage_pilot_only;
                    s_next.first_out = '0;
                end
            default: s_next.stage = burner_mon_pkg::stage_locked;
        endcase

        // Interlock trip wins over every stage but locked; lowest index taken if simultaneous
        if (!locked && (ilk_trip != 4'h0))
        begin
            s_next.stage = burner_mon_pkg::stage_locked;
            s_next.first_out = ilk_trip & (~ilk_trip + 4'h1);
        end

        // Set wins over the reset strobe
        if (plant_i.ignition_failure_err)
        begin
            s_next.ign_fail = 1'b1;
        end
        else if (err_reset)
        begin
            s_next.ign_fail = 1'b0;
        end

        if (req_i.wr)
        begin
            unique case (req_i.addr)
                burner_mon_pkg::ADDR_CTRL:
                begin
                    s_next.linked = req_i.wdata[burner_mon_pkg::CTRL_LINKED_BIT];
                    s_next.flicker_en = req_i.wdata[burner_mon_pkg::CTRL_FLICKER_BIT];
                    s_next.dual = req_i.wdata[burner_mon_pkg::CTRL_DUAL_BIT];
                end
                burner_mon_pkg::ADDR_DELAY:
                    for (int i = 0; i < 4; i++)
                    begin
                        s_next.delay_s[i] = (req_i.wdata[4*i +: 4] > burner_mon_pkg::OFF_DELAY_MAX_S)
                            ? burner_mon_pkg::OFF_DELAY_MAX_S : req_i.wdata[4*i +: 4];
                    end
                burner_mon_pkg::ADDR_FUNC: s_next.func = req_i.wdata[7:0];
                burner_mon_pkg::ADDR_SEL_LO: s_next.sel[7:0] = req_i.wdata;
                burner_mon_pkg::ADDR_SEL_HI: s_next.sel[10:8] = req_i.wdata[11:0];
                default: ;
            endcase
        end

        s_next.rdata = '0;
        if (req_i.rd)
        begin
            unique case (req_i.addr)
                burner_mon_pkg::ADDR_CTRL:
                    s_next.rdata = {29'h0, s_reg.dual, s_reg.flicker_en, s_reg.linked};
                burner_mon_pkg::ADDR_DELAY: s_next.rdata = {16'h0, s_reg.delay_s};
                burner_mon_pkg::ADDR_FUNC: s_next.rdata = {24'h0, s_reg.func};
                burner_mon_pkg::ADDR_SEL_LO: s_next.rdata = s_reg.sel[7:0];
                burner_mon_pkg::ADDR_SEL_HI: s_next.rdata = {20'h0, s_reg.sel[10:8]};
                burner_mon_pkg::ADDR_STATUS:
                    s_next.rdata = {23'h0, s_reg.ign_fail, s_reg.first_out, s_reg.stage};
                burner_mon_pkg::ADDR_MON: s_next.rdata = {21'h0, s_reg.mon};
                default: s_next.rdata = '0;
            endcase
        end

        for (int m = 0; m < burner_mon_pkg::N_MON; m++)
        begin
            s_next.mon[m] = sel_value(s_reg.sel[m], fo_view, plant_i, locked,
                                      s_reg.ign_fail, s_reg.dual);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.stage <= burner_mon_pkg::stage_pilot_only;
            s_reg.sel <= {11{burner_mon_pkg::SEL_OFF}};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign stage_o = s_reg.stage;
    assign lockout_o = locked;
    assign monitor_out_lines_o = s_reg.mon;

    ////////////////////////////////////////////////////////////////////////
    sequence s_start_in_pilot;
        s_reg.stage == burner_mon_pkg::stage_pilot_only && main_start_i
            && !(s_reg.linked && !air_switch_i) && ilk_trip == 4'h0;
    endsequence

    property p_start_trial;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_start_in_pilot |=> s_reg.stage == burner_mon_pkg::stage_main_trial;
    endproperty
    a_start_trial: assert property (p_start_trial) else $error("no main trial");

    property p_trial_holds;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.stage == burner_mon_pkg::stage_main_trial && !main_trial_done_i
            && ilk_trip == 4'h0 |=> s_reg.stage == burner_mon_pkg::stage_main_trial;
    endproperty
    a_trial_holds: assert property (p_trial_holds) else $error("trial left early");

    property p_trial_end;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.stage == burner_mon_pkg::stage_main_trial && main_trial_done_i
            && ilk_trip == 4'h0 |=> s_reg.stage == burner_mon_pkg::stage_pilot_only;
    endproperty
    a_trial_end: assert property (p_trial_end) else $error("no return to pilot");

    property p_air_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.stage == burner_mon_pkg::stage_air_wait && !air_switch_i
            |=> s_reg.stage != burner_mon_pkg::stage_main_trial;
    endproperty
    a_air_hold: assert property (p_air_hold) else $error("trial without air");

    property p_air_lock;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.stage == burner_mon_pkg::stage_air_wait && !air_switch_i
            && s_reg.air_cnt == burner_mon_pkg::AIR_WAIT_TICKS |=> locked;
    endproperty
    a_air_lock: assert property (p_air_lock) else $error("no air lockout");

    property p_delay_cap;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.sec_cnt[0] <= burner_mon_pkg::OFF_DELAY_MAX_S
            && s_reg.delay_s[0] <= burner_mon_pkg::OFF_DELAY_MAX_S;
    endproperty
    a_delay_cap: assert property (p_delay_cap) else $error("delay over range");

    property p_ilk_lock;
        @(posedge clk_sys_i) disable iff (rst_i)
        ilk_trip != 4'h0 |=> locked && s_reg.first_out != 4'h0;
    endproperty
    a_ilk_lock: assert property (p_ilk_lock) else $error("interlock not locked");

    property p_unused_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.func[0] == burner_mon_pkg::FUNC_UNUSED |-> !fo_view[0];
    endproperty
    a_unused_off: assert property (p_unused_off) else $error("unused shows on");

    property p_mon_lock;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_reg.sel[9] == burner_mon_pkg::SEL_LOCKOUT |=> monitor_out_lines_o[9] == $past(locked);
    endproperty
    a_mon_lock: assert property (p_mon_lock) else $error("alarm mismatch");

endmodule

// ---- dv/burner_field_model.sv ----
// Field side model: contacts, air switch, load feedback and flame signals.
// Assumes the bench sets wanted levels; they reach the block one edge later.
module burner_field_model (
    input wire logic clk_sys_i,
    input wire logic [3:0] want_fields_i,
    input wire logic want_air_i,
    input wire burner_mon_pkg::plant_t want_plant_i,
    output logic [3:0] fields_o,
    output logic air_o,
    output burner_mon_pkg::plant_t plant_o
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Start closed and quiet so the block sees known levels from time zero
    initial
    begin
        fields_o = 4'hf;
        air_o = 1'b1;
        plant_o = '0;
    end

    // Contacts are held levels: no release state, they only change on command
    always @(posedge clk_sys_i)
    begin
        fields_o <= want_fields_i;
        air_o <= want_air_i;
        plant_o <= want_plant_i;
    end
endmodule

// ---- dv/burner_sequence_monitor_outputs_bench.sv ----
// Self-checking bench for the burner sequence and monitor output block.
// Assumes the field model in its own file; long second counts are not reached.
module burner_sequence_monitor_outputs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_i;
    logic rst_i;
    burner_mon_pkg::reg_req_t req;
    logic [31:0] rdata;
    logic main_start;
    logic main_done;
    logic [3:0] want_f;
    logic [3:0] fields;
    logic want_air;
    logic air;
    burner_mon_pkg::plant_t want_p;
    burner_mon_pkg::plant_t plant;
    logic [3:0] stage;
    logic lockout;
    logic [10:0] mon;
    logic [31:0] ctrl;
    logic [31:0] rv;
    int err_count;
    int check_count;

    burner_seq_monitor i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
        .main_start_i(main_start), .air_switch_i(air), .main_trial_done_i(main_done),
        .field_inputs_i(fields), .plant_i(plant), .stage_o(stage),
        .lockout_o(lockout), .monitor_out_lines_o(mon));

    burner_field_model i_field (
        .clk_sys_i(clk_sys_i), .want_fields_i(want_f), .want_air_i(want_air),
        .want_plant_i(want_p), .fields_o(fields), .air_o(air), .plant_o(plant));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sample just after the edge so that edge's register updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Error reset is a strobe bit; the rest of the control word is kept
    task automatic err_reset();
        wr_reg(burner_mon_pkg::ADDR_CTRL, ctrl | 32'h0000_0008);
        settle(3);
    endtask

    task automatic wrap_up();
        $display("Checks: %0d, mismatches: %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(stage, 32'h0000_0001);
        chk(lockout, 32'h0000_0000);
        chk(mon, 32'h0000_0000);
        rd_reg(burner_mon_pkg::ADDR_SEL_LO, rv);
        chk(rv, 32'hffff_ffff);
        rd_reg(4'hf, rv);
        chk(rv, 32'h0000_0000);
    endtask

    task automatic t_sequence();
        @(posedge clk_sys_i);
        main_start <= 1'b1;
        settle(4);
        chk(stage, 32'h0000_0002);
        @(posedge clk_sys_i);
        main_start <= 1'b0;
        settle(4);
        chk(stage, 32'h0000_0002);
        @(posedge clk_sys_i);
        main_done <= 1'b1;
        @(posedge clk_sys_i);
        main_done <= 1'b0;
        settle(3);
        chk(stage, 32'h0000_0001);
    endtask

    task automatic t_linked();
        ctrl = 32'h0000_0001;
        wr_reg(burner_mon_pkg::ADDR_CTRL, ctrl);
        @(posedge clk_sys_i);
        want_air <= 1'b0;
        @(posedge clk_sys_i);
        main_start <= 1'b1;
        settle(4);
        chk(stage, 32'h0000_0004);
        @(posedge clk_sys_i);
        main_start <= 1'b0;
        settle(4);
        chk(stage, 32'h0000_0004);
        @(posedge clk_sys_i);
        want_air <= 1'b1;
        settle(4);
        chk(stage, 32'h0000_0002);
        @(posedge clk_sys_i);
        main_done <= 1'b1;
        @(posedge clk_sys_i);
        main_done <= 1'b0;
        settle(3);
        chk(stage, 32'h0000_0001);
        ctrl = 32'h0000_0000;
        wr_reg(burner_mon_pkg::ADDR_CTRL, ctrl);
    endtask

    // Monitors 5..9 carry ignition, pilot, main, flame primary, flame secondary
    task automatic t_loads();
        logic [4:0] exp;
        wr_reg(burner_mon_pkg::ADDR_SEL_LO, 32'h7654_3214);
        wr_reg(burner_mon_pkg::ADDR_SEL_HI, 32'h0000_0a98);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys_i);
            want_p <= 6'(6'h20 >> i);
            settle(4);
            exp = (i == 4) ? 5'h00 : 5'(5'h01 << i);
            chk(mon[8:4], exp);
            chk(mon[0], (i == 0) ? 1'b1 : 1'b0);
        end
        ctrl = 32'h0000_0004;
        wr_reg(burner_mon_pkg::ADDR_CTRL, ctrl);
        settle(4);
        chk(mon[8], 32'h0000_0001);
        @(posedge clk_sys_i);
        want_p <= '0;
        wr_reg(burner_mon_pkg::ADDR_SEL_LO, 32'h7654_3210);
        settle(4);
        chk(mon[8:0], 32'h0000_0000);
    endtask

    // Input 1 unused, 2 control, 3 and 4 interlock, all with zero OFF delay
    task automatic t_inputs();
        wr_reg(burner_mon_pkg::ADDR_FUNC, 32'h0000_00a4);
        wr_reg(burner_mon_pkg::ADDR_DELAY, 32'h0000_0000);
        settle(4);
        chk(mon[3:0], 32'h0000_0002);
        @(posedge clk_sys_i);
        want_f <= 4'h7;
        settle(4);
        chk(lockout, 32'h0000_0001);
        chk(stage, 32'h0000_0008);
        chk(mon[3:0], 32'h0000_000a);
        chk(mon[9], 32'h0000_0001);
        @(posedge clk_sys_i);
        want_f <= 4'h3;
        for (int i = 0; i < 20; i++)
        begin
            settle(1);
            chk(mon[3:2], 32'h0000_0002);
        end
        // Flicker phase starts low, so the first half second shows the line off
        wr_reg(burner_mon_pkg::ADDR_CTRL, ctrl | 32'h0000_0002);
        settle(3);
        chk(mon[3], 32'h0000_0000);
        wr_reg(burner_mon_pkg::ADDR_CTRL, ctrl);
        settle(3);
        chk(mon[3], 32'h0000_0001);
        @(posedge clk_sys_i);
        want_f <= 4'hf;
        settle(3);
        err_reset();
        chk(lockout, 32'h0000_0000);
        chk(mon[9], 32'h0000_0000);
        chk(mon[3:0], 32'h0000_0002);
    endtask

    task automatic t_ignfail();
        @(posedge clk_sys_i);
        want_p <= 6'h01;
        @(posedge clk_sys_i);
        want_p <= 6'h00;
        settle(12);
        chk(mon[10], 32'h0000_0001);
        rd_reg(burner_mon_pkg::ADDR_STATUS, rv);
        chk(rv[8], 32'h0000_0001);
        err_reset();
        chk(mon[10], 32'h0000_0000);
    endtask

    // A delay field above ten seconds must settle at the ten second ceiling
    task automatic t_regs();
        wr_reg(burner_mon_pkg::ADDR_DELAY, 32'h0000_f000);
        rd_reg(burner_mon_pkg::ADDR_DELAY, rv);
        chk(rv, 32'h0000_a000);
        rd_reg(burner_mon_pkg::ADDR_MON, rv);
        chk(rv, 32'h0000_0002);
    endtask

    // One second delays on inputs 2 and 3: the control line holds, the interlock waits
    task automatic t_delays();
        wr_reg(burner_mon_pkg::ADDR_DELAY, 32'h0000_0110);
        @(posedge clk_sys_i);
        want_f <= 4'h9;
        settle(20);
        chk(mon[2:1], 32'h0000_0001);
        chk(lockout, 32'h0000_0000);
        @(posedge clk_sys_i);
        want_f <= 4'hd;
        settle(3);
        wr_reg(burner_mon_pkg::ADDR_DELAY, 32'h0000_0000);
        settle(3);
        chk(mon[1], 32'h0000_0000);
        chk(lockout, 32'h0000_0000);
        @(posedge clk_sys_i);
        want_f <= 4'hf;
        settle(3);
        chk(mon[1], 32'h0000_0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_i = 1'b1;
        req = '0;
        main_start = 1'b0;
        main_done = 1'b0;
        want_f = 4'hf;
        want_air = 1'b1;
        want_p = '0;
        ctrl = 32'h0000_0000;
        err_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        settle(1);
        t_reset();
        t_sequence();
        t_linked();
        t_loads();
        t_inputs();
        t_ignfail();
        t_regs();
        t_delays();
        wrap_up();
    end

    // Whole run needs well under a thousand cycles; this cuts off a hang
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule
